// ---- inc/emb_pkg.sv ----
// Constants, types and carriers shared by the external memory bus controller.
// Operation
// - Port two emits high address on fetch/pointer.
// - Byte-register data access shows port two latch.
// - Latch one means weak pull-up, input use.
// - Reset needs input high two machine cycles.
// - Address strobe pulses on each external access.
// - Address strobe runs at oscillator over six.
// - One address strobe dropped per data access.
// - Bit zero at 8EH disables address strobe.
// - Disabled strobe only on moves, else weak-high.
// - External execution ignores the strobe disable bit.
// - Fetch strobe twice per machine cycle externally.
// - Two fetch strobes dropped per data access.
// - Select low: all code fetched externally, full range.
// - Select high: execute from internal program memory.
// - Lock bit one latches select at reset.
// - Port one bits zero, one carry timer two.
// - Port one bits four to seven carry SPI.
// - Port three bits carry serial, irq, timers, strobes.
package emb_pkg;

  // Oscillator clocks in one machine cycle and the last phase index.
  localparam int OSC_PER_MC = 12;
  localparam logic [3:0] PH_LAST = 4'hb;
  // Address strobe slots: two pulses of two clocks, six clocks apart.
  localparam logic [3:0] PH_ALE_A = 4'h0;
  localparam logic [3:0] PH_ALE_B = 4'h6;
  // Fetch strobe slots: two pulses of three clocks each.
  localparam logic [3:0] PH_PROGRAM_FETCH_STROBE_A = 4'h3;
  localparam logic [3:0] PH_PROGRAM_FETCH_STROBE_B = 4'h9;
  localparam logic [3:0] PROGRAM_FETCH_STROBE_SPAN = 4'h2;
  // Data read or write strobe window within the data machine cycle.
  localparam logic [3:0] PH_STB_FIRST = 4'h3;
  localparam logic [3:0] PH_STB_LAST = 4'h9;
  // Reset qualification length.
  localparam int RST_MC = 2;
  localparam int RST_CYC = RST_MC * OSC_PER_MC;
  // Location of the address strobe disable control; the bit enters as a port.
  localparam logic [7:0] SFR_ALE_CTRL_ADDR = 8'h8e;
  localparam int ALE_DIS_BIT = 0;
  // Port latch value after reset and the external code range.
  localparam logic [7:0] PORT_LATCH_RST = 8'hff;
  localparam logic [15:0] CODE_BASE = 16'h0000;
  localparam logic [15:0] CODE_TOP = 16'hffff;
  // Alternate function bit positions of port one and port three.
  localparam int P1_T2 = 0;
  localparam int P1_TIMER_TWO_TRIGGER_INPUT = 1;
  localparam int P1_SS = 4;
  localparam int P1_MOSI = 5;
  localparam int P1_MISO = 6;
  localparam int P1_SCK = 7;
  localparam int P3_RXD = 0;
  localparam int P3_TXD = 1;
  localparam int P3_IRQ0 = 2;
  localparam int P3_IRQ1 = 3;
  localparam int P3_T0 = 4;
  localparam int P3_T1 = 5;
  localparam int P3_WR = 6;
  localparam int P3_RD = 7;

  // Kind of the current machine cycle on the bus.
  typedef enum logic [2:0] {
    BS_IDLE = 3'b001,
    BS_FETCH = 3'b010,
    BS_DATA = 3'b100
  } emb_bus_st_t;

  // Request from the core, taken at the end of each machine cycle.
  typedef struct packed {
    logic ext_data;
    logic use_ptr16;
    logic write;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [15:0] pc;
  } emb_req_t;

  // Alternate outputs from the peripherals.
  typedef struct packed {
    logic txd;
    logic t2_clkout;
    logic mosi;
    logic miso;
    logic sck;
  } emb_alt_out_t;

  // Alternate inputs routed to the peripherals.
  typedef struct packed {
    logic rxd;
    logic ext_irq_zero;
    logic ext_irq_one;
    logic timer_zero_count_input;
    logic timer_one_count_input;
    logic timer_two_count_input;
    logic timer_two_trigger_input;
    logic ss;
    logic mosi;
    logic miso;
    logic sck;
  } emb_alt_in_t;

endpackage

// ---- design/emb_pin.sv ----
// Quasi-bidirectional port pin cell with an address override.
`timescale 1ns/1ps
`default_nettype none
module emb_pin
  import emb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic latch,
  input wire logic alt_o,
  input wire logic force_en,
  input wire logic force_val,
  output logic pad_o,
  output logic pad_oe
);

  // Next pad value and strong drive enable, registered below.
  logic pad_o_d;
  logic pad_oe_d;

  // An override drives both levels hard; otherwise only a low is driven and
  // a one leaves the pin on its weak pull-up so it can be read.
  always_comb
  begin
    if (force_en)
    begin
      pad_o_d = force_val;
      pad_oe_d = 1'b1;
    end
    else
    begin
      pad_o_d = latch & alt_o;
      pad_oe_d = ~(latch & alt_o);
    end
  end

  // Reset leaves the pin released and pulled high.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pad_o <= 1'b1;
      pad_oe <= 1'b0;
    end
    else
    begin
      pad_o <= pad_o_d;
      pad_oe <= pad_oe_d;
    end
  end

endmodule
`default_nettype wire

// ---- design/emb_rst_qual.sv ----
// Qualifies the reset pin over a minimum number of oscillator clocks.
`timescale 1ns/1ps
`default_nettype none
module emb_rst_qual
  import emb_pkg::*;
#(
  parameter int CNT = RST_CYC
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic rst_pin,
  output logic core_rst
);

  localparam int W = $clog2(CNT + 1);
  localparam logic [W-1:0] CNT_MAX = W'(CNT);

  // Count of consecutive clocks with the pin high, saturating at the limit.
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic core_rst_d;

  // A short glitch restarts the count, so noise never resets the core.
  always_comb
  begin
    if (!rst_pin)
      cnt_d = '0;
    else if (cnt_q != CNT_MAX)
      cnt_d = cnt_q + 1'b1;
    else
      cnt_d = cnt_q;
    core_rst_d = rst_pin && (cnt_d == CNT_MAX);
  end

  // The core is held in reset while the system reset is active.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      core_rst <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      core_rst <= core_rst_d;
    end
  end

endmodule
`default_nettype wire

// ---- design/emb_bus_ctrl.sv ----
// External memory bus controller: strobes, port two address, port alternates.
`timescale 1ns/1ps
`default_nettype none
module emb_bus_ctrl
  import emb_pkg::*;
#(
  parameter int RST_CNT = RST_CYC
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic rst_pin,
  input wire logic external_fetch_select,
  input wire logic lock_bit1,
  input wire logic ale_disable,
  input wire logic move_instr,
  input wire emb_req_t req,
  input wire logic [7:0] port_one_latch,
  input wire logic [7:0] port_two_latch,
  input wire logic [7:0] port_three_latch,
  input wire emb_alt_out_t alt_out,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p3_in,
  output logic core_rst,
  output logic ext_exec,
  output logic mc_end,
  output logic ale_o,
  output logic ale_oe,
  output logic program_fetch_strobe_n,
  output logic [7:0] addr_lo,
  output logic [7:0] p1_o,
  output logic [7:0] p1_oe,
  output logic [7:0] p2_o,
  output logic [7:0] p2_oe,
  output logic [7:0] p3_o,
  output logic [7:0] p3_oe,
  output emb_alt_in_t alt_in
);

  // Phase within the machine cycle and the kind of the current cycle.
  logic [3:0] phase_q, phase_d;
  emb_bus_st_t st_q, st_d;
  // Request held for the whole machine cycle it was taken for.
  emb_req_t req_q, req_d;
  // Captured level of the fetch select pin and the effective mode.
  logic ea_cap_q, ea_cap_d, ea_eff, ext_exec_d;
  // Registered strobe outputs and their next values.
  logic ale_o_d, ale_oe_d, program_fetch_strobe_n_d;
  logic rd_n_q, rd_n_d, wr_n_q, wr_n_d;
  logic [7:0] addr_lo_d;
  // Decoded slots of the current phase.
  logic in_ale, ale_skip, ale_gate, in_program_fetch_strobe, in_stb;
  // Port two override and alternate output vectors.
  logic p2_force;
  logic [7:0] p2_val, p1_alt, p3_alt;
  emb_alt_in_t alt_in_d;
  // Flattened view of all twenty-four pins for the cell array.
  logic [23:0] latch_all, alt_all, force_all;
  logic [23:0] fval_all, pad_o_all, pad_oe_all;

  // Pin-level reset qualification feeds the core reset.
  emb_rst_qual #(
    .CNT(RST_CNT)
  ) u_rst (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .rst_pin(rst_pin),
    .core_rst(core_rst)
  );

  // The select pin is sampled throughout reset so the held value is the one
  // present at its release; without the lock the live pin decides.
  always_comb
  begin
    ea_cap_d = core_rst ? external_fetch_select : ea_cap_q;
    ea_eff = lock_bit1 ? ea_cap_q : external_fetch_select;
    ext_exec_d = ~ea_eff;
  end

  // Machine cycle sequencer: phase counter and cycle kind.
  always_comb
  begin
    mc_end = (phase_q == PH_LAST);
    phase_d = mc_end ? 4'h0 : phase_q + 4'h1;
    st_d = st_q;
    req_d = req_q;
    if (mc_end)
    begin
      req_d = req;
      // Any code address reaches the external bus while executing outside.
      if (req.ext_data)
        st_d = BS_DATA;
      else if (ext_exec)
        st_d = BS_FETCH;
      else
        st_d = BS_IDLE;
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || core_rst)
    begin
      phase_q <= 4'h0;
      st_q <= BS_IDLE;
      req_q <= '0;
    end
    else
    begin
      phase_q <= phase_d;
      st_q <= st_d;
      req_q <= req_d;
    end
  end

  // Mode registers; only the system reset resets them so the capture works.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ea_cap_q <= 1'b1;
      ext_exec <= 1'b0;
    end
    else
    begin
      ea_cap_q <= ea_cap_d;
      ext_exec <= ext_exec_d;
    end
  end

  // Strobe generation for the next clock.
  always_comb
  begin
    in_ale = (phase_q == PH_ALE_A) || (phase_q == PH_ALE_A + 4'h1) ||
             (phase_q == PH_ALE_B) || (phase_q == PH_ALE_B + 4'h1);
    // The second pulse of a data cycle is dropped, the first latches the
    // data address.
    ale_skip = (st_q == BS_DATA) &&
               ((phase_q == PH_ALE_B) || (phase_q == PH_ALE_B + 4'h1));
    // The disable bit only holds while executing inside and outside moves.
    ale_gate = ext_exec || !ale_disable || move_instr;
    ale_oe_d = ale_gate;
    if (ale_gate)
      ale_o_d = in_ale && !ale_skip;
    else
      ale_o_d = 1'b1;
    in_program_fetch_strobe = ((phase_q >= PH_PROGRAM_FETCH_STROBE_A) && (phase_q <= PH_PROGRAM_FETCH_STROBE_A + PROGRAM_FETCH_STROBE_SPAN)) ||
              ((phase_q >= PH_PROGRAM_FETCH_STROBE_B) && (phase_q <= PH_PROGRAM_FETCH_STROBE_B + PROGRAM_FETCH_STROBE_SPAN));
    // Only fetch cycles strobe; a data cycle therefore loses both.
    program_fetch_strobe_n_d = !((st_q == BS_FETCH) && in_program_fetch_strobe);
    in_stb = (st_q == BS_DATA) && (phase_q >= PH_STB_FIRST) &&
             (phase_q <= PH_STB_LAST);
    rd_n_d = !(in_stb && !req_q.write);
    wr_n_d = !(in_stb && req_q.write);
    addr_lo_d = (st_q == BS_DATA) ? req_q.addr_lo : req_q.pc[7:0];
  end

  // Strobe registers; reset leaves every strobe high, the address strobe released.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || core_rst)
    begin
      ale_o <= 1'b1;
      ale_oe <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      addr_lo <= 8'h00;
    end
    else
    begin
      ale_o <= ale_o_d;
      ale_oe <= ale_oe_d;
      program_fetch_strobe_n <= program_fetch_strobe_n_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      addr_lo <= addr_lo_d;
    end
  end

  // Port two override and alternate output muxing for ports one and three.
  always_comb
  begin
    p2_force = 1'b0;
    p2_val = 8'h00;
    if (st_q == BS_FETCH)
    begin
      p2_force = 1'b1;
      p2_val = req_q.pc[15:8];
    end
    else if ((st_q == BS_DATA) && req_q.use_ptr16)
    begin
      p2_force = 1'b1;
      p2_val = req_q.addr_hi;
    end
    // A byte-register access leaves port two on its own latch.
    p1_alt = 8'hff;
    p1_alt[P1_T2] = alt_out.t2_clkout;
    p1_alt[P1_MOSI] = alt_out.mosi;
    p1_alt[P1_MISO] = alt_out.miso;
    p1_alt[P1_SCK] = alt_out.sck;
    p3_alt = 8'hff;
    p3_alt[P3_TXD] = alt_out.txd;
    p3_alt[P3_WR] = wr_n_q;
    p3_alt[P3_RD] = rd_n_q;
  end

  // Alternate inputs are registered so downstream logic sees clean levels.
  always_comb
  begin
    alt_in_d.timer_two_count_input = p1_in[P1_T2];
    alt_in_d.timer_two_trigger_input = p1_in[P1_TIMER_TWO_TRIGGER_INPUT];
    alt_in_d.ss = p1_in[P1_SS];
    alt_in_d.mosi = p1_in[P1_MOSI];
    alt_in_d.miso = p1_in[P1_MISO];
    alt_in_d.sck = p1_in[P1_SCK];
    alt_in_d.rxd = p3_in[P3_RXD];
    alt_in_d.ext_irq_zero = p3_in[P3_IRQ0];
    alt_in_d.ext_irq_one = p3_in[P3_IRQ1];
    alt_in_d.timer_zero_count_input = p3_in[P3_T0];
    alt_in_d.timer_one_count_input = p3_in[P3_T1];
  end

  // Alternate input register; idle value matches released, pulled-up pins.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      alt_in <= '1;
    else
      alt_in <= alt_in_d;
  end

  // One cell per pin; port two is the only one with an address override.
  assign latch_all = {port_three_latch, port_two_latch, port_one_latch};
  assign alt_all = {p3_alt, 8'hff, p1_alt};
  assign force_all = {8'h00, {8{p2_force}}, 8'h00};
  assign fval_all = {8'h00, p2_val, 8'h00};

  generate
    for (genvar i = 0; i < 24; i++)
    begin : g_pin
      emb_pin u_pin (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .latch(latch_all[i]),
        .alt_o(alt_all[i]),
        .force_en(force_all[i]),
        .force_val(fval_all[i]),
        .pad_o(pad_o_all[i]),
        .pad_oe(pad_oe_all[i])
      );
    end
  endgenerate

  assign p1_o = pad_o_all[7:0];
  assign p1_oe = pad_oe_all[7:0];
  assign p2_o = pad_o_all[15:8];
  assign p2_oe = pad_oe_all[15:8];
  assign p3_o = pad_o_all[23:16];
  assign p3_oe = pad_oe_all[23:16];

  // Checks on the bus timing, watched outside any reset; the reset pin check is off only during the system reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst || core_rst);

  property p_p2_addr;
    (st_q == BS_FETCH) |=> (p2_oe == 8'hff) && (p2_o == $past(req_q.pc[15:8]));
  endproperty
  a_p2_addr: assert property (p_p2_addr) else $error("port two lost fetch address");
  property p_p2_latch;
    (st_q == BS_DATA) && !req_q.use_ptr16 |=> (p2_o == $past(port_two_latch));
  endproperty
  a_p2_latch: assert property (p_p2_latch) else $error("port two not latch");
  property p_weak;
    (st_q == BS_IDLE) |=> (p2_oe == ~$past(port_two_latch));
  endproperty
  a_weak: assert property (p_weak) else $error("port two drives a one");
  property p_rst;
    @(posedge clk_sys) disable iff (sys_rst) !rst_pin |=> !core_rst;
  endproperty
  a_rst: assert property (p_rst) else $error("reset without pin high");
  property p_ale_pulse;
    (phase_q == PH_ALE_A) && ale_gate |=> ale_o ##1 ale_o ##1 !ale_o;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("address strobe missing");
  property p_ale_rate;
    $rose(ale_o) && ale_oe && (phase_q == PH_ALE_A + 4'h1) && (st_q != BS_DATA) |->
      ##6 $rose(ale_o);
  endproperty
  a_ale_rate: assert property (p_ale_rate) else $error("address strobe rate wrong");
  property p_ale_skip;
    (st_q == BS_DATA) && (phase_q == PH_ALE_B) |=> !ale_o [*3];
  endproperty
  a_ale_skip: assert property (p_ale_skip) else $error("data strobe skip missing");
  property p_ale_dis;
    ale_disable && !ext_exec && !move_instr |=> !ale_oe && ale_o;
  endproperty
  a_ale_dis: assert property (p_ale_dis) else $error("disabled strobe not resting");
  property p_ale_ext;
    ext_exec && (phase_q == PH_ALE_B) && (st_q == BS_FETCH) |=> ale_oe && ale_o;
  endproperty
  a_ale_ext: assert property (p_ale_ext) else $error("disable acted in external mode");
  property p_program_fetch_strobe;
    (st_q == BS_FETCH) && (phase_q == PH_PROGRAM_FETCH_STROBE_A) |=>
      !program_fetch_strobe_n [*3] ##1 program_fetch_strobe_n;
  endproperty
  a_program_fetch_strobe: assert property (p_program_fetch_strobe) else $error("fetch strobe wrong");
  property p_program_fetch_strobe_skip;
    (st_q == BS_DATA) |=> program_fetch_strobe_n;
  endproperty
  a_program_fetch_strobe_skip: assert property (p_program_fetch_strobe_skip) else $error("fetch strobe in data cycle");
  property p_select;
    !lock_bit1 && ($past(external_fetch_select) == external_fetch_select) |=>
      (ext_exec == !$past(external_fetch_select));
  endproperty
  a_select: assert property (p_select) else $error("fetch select ignored");
  property p_lock;
    lock_bit1 && $past(lock_bit1) |=> $stable(ext_exec);
  endproperty
  a_lock: assert property (p_lock) else $error("locked select changed");
  property p_rdwr;
    (st_q != BS_DATA) |=> rd_n_q && wr_n_q ##1 p3_o[P3_RD] == $past(port_three_latch[P3_RD]);
  endproperty
  a_rdwr: assert property (p_rdwr) else $error("data strobe outside move");

  c_read: cover property ((st_q == BS_DATA) && !req_q.write && !rd_n_q);
  c_write: cover property ((st_q == BS_DATA) && req_q.write && !wr_n_q);
  c_rest: cover property (!ale_oe ##1 !ale_oe ##1 ale_oe);
  c_fetch: cover property ((st_q == BS_FETCH) && !program_fetch_strobe_n);

endmodule
`default_nettype wire

// ---- tb/emb_mem_model.sv ----
// Far-side model: external memory, address latch and the board's port pins.
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model
  import emb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ale_o,
  input wire logic ale_oe,
  input wire logic program_fetch_strobe_n,
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] p1_o,
  input wire logic [7:0] p1_oe,
  input wire logic [7:0] p2_o,
  input wire logic [7:0] p2_oe,
  input wire logic [7:0] p3_o,
  input wire logic [7:0] p3_oe,
  input wire logic [7:0] p1_pull_low,
  input wire logic [7:0] p3_pull_low,
  output logic ale_pin,
  output logic [7:0] p1_pin,
  output logic [7:0] p2_pin,
  output logic [7:0] p3_pin,
  output logic [7:0] latched_lo,
  output logic [15:0] fetch_count
);
  // Previous strobe levels, used to find the falling edges.
  logic ale_prev_q;
  logic fs_prev_q;
  // A released pin is held high by the weak pull-up unless the board pulls it low.
  assign ale_pin = ale_oe ? ale_o : 1'b1;
  assign p1_pin = (p1_oe & p1_o) | (~p1_oe & ~p1_pull_low);
  assign p2_pin = (p2_oe & p2_o) | ~p2_oe;
  assign p3_pin = (p3_oe & p3_o) | (~p3_oe & ~p3_pull_low);
  // The address latch closes on the falling strobe; code reads are counted.
  always_ff @(posedge clk_sys)
  begin
    ale_prev_q <= ale_pin;
    fs_prev_q <= program_fetch_strobe_n;
    if (ale_prev_q && !ale_pin)
    begin
      latched_lo <= addr_lo;
    end
    // The code read count starts from zero at every system reset.
    if (sys_rst)
    begin
      fetch_count <= 16'h0000;
    end
    else if (fs_prev_q && !program_fetch_strobe_n)
    begin
      fetch_count <= fetch_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_external_memory_bus_control.sv ----
// Self-checking testbench for the external memory bus controller.
`timescale 1ns/1ps
`default_nettype none
module tb_external_memory_bus_control;
  import emb_pkg::*;
  localparam int RST_SMALL = 3;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic rst_pin = 1'b0;
  logic external_fetch_select = 1'b1;
  logic lock_bit1 = 1'b0;
  logic ale_disable = 1'b0;
  logic move_instr = 1'b0;
  emb_req_t req = '0;
  logic [7:0] port_one_latch = 8'hff;
  logic [7:0] port_two_latch = 8'hff;
  logic [7:0] port_three_latch = 8'hff;
  emb_alt_out_t alt_out = 5'h1f;
  logic [7:0] p1_pull_low = 8'h00;
  logic [7:0] p3_pull_low = 8'h00;
  logic core_rst, ext_exec, mc_end, ale_o, ale_oe, fs_n, ale_pin;
  logic [7:0] addr_lo, p1_o, p1_oe, p2_o, p2_oe, p3_o, p3_oe;
  logic [7:0] p1_pin, p2_pin, p3_pin, latched_lo;
  logic [15:0] fetch_count;
  emb_alt_in_t alt_in;
  // Per machine cycle results gathered by run_mc.
  int n_ale, n_fs, n_rd, n_wr;
  logic [7:0] p2_mid, p2oe_mid;
  int bad_count = 0;
  int total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  emb_bus_ctrl #(.RST_CNT(RST_SMALL)) u_emb_bus_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .rst_pin(rst_pin), .external_fetch_select(external_fetch_select), .lock_bit1(lock_bit1),
    .ale_disable(ale_disable), .move_instr(move_instr), .req(req),
    .port_one_latch(port_one_latch), .port_two_latch(port_two_latch),
    .port_three_latch(port_three_latch), .alt_out(alt_out), .p1_in(p1_pin), .p3_in(p3_pin),
    .core_rst(core_rst), .ext_exec(ext_exec), .mc_end(mc_end), .ale_o(ale_o), .ale_oe(ale_oe),
    .program_fetch_strobe_n(fs_n), .addr_lo(addr_lo), .p1_o(p1_o), .p1_oe(p1_oe),
    .p2_o(p2_o), .p2_oe(p2_oe), .p3_o(p3_o), .p3_oe(p3_oe), .alt_in(alt_in));
  emb_mem_model u_emb_mem_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .ale_o(ale_o),
    .ale_oe(ale_oe),
    .program_fetch_strobe_n(fs_n), .addr_lo(addr_lo), .p1_o(p1_o), .p1_oe(p1_oe),
    .p2_o(p2_o), .p2_oe(p2_oe), .p3_o(p3_o), .p3_oe(p3_oe), .p1_pull_low(p1_pull_low),
    .p3_pull_low(p3_pull_low), .ale_pin(ale_pin), .p1_pin(p1_pin), .p2_pin(p2_pin),
    .p3_pin(p3_pin), .latched_lo(latched_lo), .fetch_count(fetch_count));
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits a number of edges; inputs then change 1 ns after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Hands req over at the next cycle end and samples the machine cycle that follows.
  task automatic run_mc(input emb_req_t r);
    logic ale_prev, fs_prev;
    int guard;
    guard = 0;
    while (mc_end !== 1'b1 && guard < 40)
    begin
      tick(1);
      guard++;
    end
    // A sequencer that never reaches its cycle end counts as a mismatch.
    if (guard >= 40)
    begin
      bad_count++;
      $display("[FAIL] cycle end expected 1 seen %b", mc_end);
    end
    req = r;
    tick(1);
    {n_ale, n_fs, n_rd, n_wr} = '0;
    ale_prev = ale_pin;
    fs_prev = fs_n;
    for (int i = 1; i <= OSC_PER_MC; i++)
    begin
      tick(1);
      if (ale_pin && !ale_prev) n_ale++;
      if (!fs_n && fs_prev) n_fs++;
      if (p3_pin[P3_RD] === 1'b0) n_rd++;
      if (p3_pin[P3_WR] === 1'b0) n_wr++;
      if (i == 6) {p2_mid, p2oe_mid} = {p2_pin, p2_oe};
      ale_prev = ale_pin;
      fs_prev = fs_n;
    end
  endtask
  // Device reset through the pin with the fetch select level given.
  task automatic pin_reset(input logic ea);
    external_fetch_select = ea;
    rst_pin = 1'b1;
    tick(RST_SMALL + 3);
    rst_pin = 1'b0;
    tick(3);
    chk("core_rst", 16'h0, core_rst);
    chk("ext_exec", {15'h0, !ea}, ext_exec);
  endtask
  // Internal execution: strobe at a sixth of the clock, no code reads, disable honoured.
  task automatic t_internal();
    pin_reset(1'b1);
    run_mc('0);
    chk("ale pulses", 16'h2, n_ale);
    chk("fetch strobes", 16'h0, n_fs);
    ale_disable = 1'b1;
    run_mc('0);
    run_mc('0);
    chk("ale pulses disabled", 16'h0, n_ale);
    chk("ale released", 16'h0, ale_oe);
    move_instr = 1'b1;
    run_mc('0);
    run_mc('0);
    chk("ale pulses on move", 16'h2, n_ale);
    chk("code reads", 16'h0, fetch_count);
    move_instr = 1'b0;
  endtask
  // Reset pin must be high the full qualifying time.
  task automatic t_reset_len();
    rst_pin = 1'b1;
    tick(RST_SMALL - 1);
    chk("short reset", 16'h0, core_rst);
    tick(2);
    chk("long reset", 16'h1, core_rst);
    rst_pin = 1'b0;
    tick(3);
  endtask
  // External execution: fetches at both ends of code space, disable bit ignored.
  task automatic t_fetch();
    emb_req_t r;
    pin_reset(1'b0);
    r = '0;
    for (int k = 0; k < 2; k++)
    begin
      r.pc = k ? CODE_BASE : CODE_TOP;
      run_mc(r);
      chk("fetch strobes", 16'h2, n_fs);
      chk("p2 high address", {8'h0, r.pc[15:8]}, p2_mid);
      chk("p2 strong drive", 16'h00ff, p2oe_mid);
      chk("ale pulses", 16'h2, n_ale);
    end
    ale_disable = 1'b0;
  endtask
  // Data cycles: one strobe skipped, no code reads, proper port two content and strobes.
  task automatic t_data();
    emb_req_t r;
    r = '0;
    r.ext_data = 1'b1;
    r.use_ptr16 = 1'b1;
    r.addr_hi = 8'h5a;
    r.addr_lo = 8'h3c;
    run_mc(r);
    chk("data ale", 16'h1, n_ale);
    chk("data fetch", 16'h0, n_fs);
    chk("latched low", 16'h3c, latched_lo);
    chk("p2 pointer", 16'h5a, p2_mid);
    chk("read active", 16'h1, n_rd > 0);
    chk("write idle", 16'h0, n_wr);
    port_two_latch = 8'h96;
    r.use_ptr16 = 1'b0;
    r.write = 1'b1;
    r.addr_lo = 8'hc3;
    run_mc(r);
    chk("p2 latch", 16'h96, p2_mid);
    chk("latched low", 16'hc3, latched_lo);
    chk("write active", 16'h1, n_wr > 0);
    chk("read idle", 16'h0, n_rd);
    r = '0;
    run_mc(r);
    run_mc(r);
    chk("no strobe on fetch", 16'h0, n_rd + n_wr);
    port_two_latch = 8'hff;
  endtask
  // Fetch select is held from reset while the lock is set.
  task automatic t_lock();
    lock_bit1 = 1'b1;
    external_fetch_select = 1'b1;
    tick(4);
    chk("ext_exec locked", 16'h1, ext_exec);
    external_fetch_select = 1'b0;
    tick(2);
    lock_bit1 = 1'b0;
  endtask
  // Quasi pins and the alternate functions of ports one and three.
  task automatic t_ports();
    port_one_latch = 8'hfe;
    p1_pull_low = 8'h52;
    p3_pull_low = 8'h15;
    alt_out.txd = 1'b0;
    alt_out.sck = 1'b0;
    tick(4);
    chk("p1 weak one", 16'h0, p1_oe[2]);
    chk("p1 pin high", 16'h1, p1_pin[2]);
    chk("p1 driven zero", 16'h0, p1_pin[P1_T2]);
    chk("t2 count", 16'h0, alt_in.timer_two_count_input);
    chk("t2 trigger", 16'h0, alt_in.timer_two_trigger_input);
    chk("spi select", 16'h0, alt_in.ss);
    chk("spi mosi", 16'h1, alt_in.mosi);
    chk("spi miso", 16'h0, alt_in.miso);
    chk("spi sck pin", 16'h0, p1_pin[P1_SCK]);
    chk("t0 count", 16'h0, alt_in.timer_zero_count_input);
    chk("t1 count", 16'h1, alt_in.timer_one_count_input);
    chk("serial rx", 16'h0, alt_in.rxd);
    chk("irq zero", 16'h0, alt_in.ext_irq_zero);
    chk("irq one", 16'h1, alt_in.ext_irq_one);
    chk("serial tx", 16'h0, p3_pin[P3_TXD]);
  endtask
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    tick(6);
    sys_rst = 1'b0;
    t_internal();
    t_reset_len();
    t_fetch();
    t_data();
    t_lock();
    t_ports();
    stop_test();
  end
  // Watchdog: the sequence needs far fewer than 20000 clocks.
  initial
  begin
    #80000;
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
